// File: hdl/isp_top.sv
// Purpose: interrupt sequencer with halt and stop power-down control
// Assumes: core reports instruction boundaries and performs stack/fetch moves
// Notes: registers reached by plain address/strobe port, read data one cycle later
//
// Chosen here: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps
module isp_top
  import isp_pkg::*;
#(
  parameter int WDT_STOP_CYC = ISP_WDT_STOP_CYC,
  parameter int WAKE_MIN_CYC = ISP_WAKE_MIN_CYC
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic srst,
  // register port
  input wire logic [1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // hardware requests and wake sources (asynchronous)
  input wire logic [ISP_LEVELS-1:0] hw_req,
  input wire logic port2_bit7_wake_pin,
  input wire logic spi_compare_match,
  input wire logic wdt_stop_enable,
  // core side
  input wire isp_pkg::isp_core_t core_in,
  input wire logic [15:0] core_pc,
  input wire logic [15:0] vec_data,
  input wire logic bus_done,
  output isp_pkg::isp_bus_t bus_out,
  output logic [15:0] branch_addr,
  output logic branch_go,
  output logic cpu_clk_en,
  output logic osc_run,
  output logic tmr_clk_en,
  output logic special_reset,
  output logic ack_active
);
  import isp_pkg::*;

  // register indices
  localparam logic [1:0] A_REQ = 2'h0;
  localparam logic [1:0] A_MASK = 2'h1;
  localparam logic [1:0] A_PRIO = 2'h2;
  localparam logic [1:0] A_SRC = 2'h3;

  // programmable priority among groups A={3,5}, B={0,2}, C={1,4}
  function automatic logic [2:0] pick(input logic [5:0] pend, input logic [5:0] pr);
    logic [2:0] g0, g1, g2;
    logic [2:0] gs [3];
    logic [2:0] res;
    logic [2:0] hi, lo;
    res = 3'h7;
    case ({pr[4], pr[3], pr[0]})
      3'b001: begin g0 = 3'd2; g1 = 3'd0; g2 = 3'd1; end
      3'b010: begin g0 = 3'd0; g1 = 3'd1; g2 = 3'd2; end
      3'b011: begin g0 = 3'd0; g1 = 3'd2; g2 = 3'd1; end
      3'b100: begin g0 = 3'd1; g1 = 3'd2; g2 = 3'd0; end
      3'b101: begin g0 = 3'd2; g1 = 3'd1; g2 = 3'd0; end
      3'b110: begin g0 = 3'd1; g1 = 3'd0; g2 = 3'd2; end
      default: begin g0 = 3'd0; g1 = 3'd1; g2 = 3'd2; end
    endcase
    gs[0] = g2;
    gs[1] = g1;
    gs[2] = g0;
    for (int i = 0; i < 3; i++) begin
      case (gs[i])
        3'd0: begin hi = pr[5] ? 3'd3 : 3'd5; lo = pr[5] ? 3'd5 : 3'd3; end
        3'd1: begin hi = pr[2] ? 3'd0 : 3'd2; lo = pr[2] ? 3'd2 : 3'd0; end
        default: begin hi = pr[1] ? 3'd4 : 3'd1; lo = pr[1] ? 3'd1 : 3'd4; end
      endcase
      // lowest group first so the highest overwrites
      if (pend[lo]) res = lo;
      if (pend[hi]) res = hi;
    end
    return res;
  endfunction : pick

  logic [5:0] req_sync;
  logic [1:0] wake_sync;
  logic [5:0] req_q, req_d;
  logic [5:0] edge_q;
  logic [7:0] mask_q;
  logic [5:0] prio_q;
  logic [7:0] src_q;
  logic armed_q;
  isp_state_t st_q, st_d;
  logic [4:0] ack_cnt_q;
  logic [2:0] lvl_q;
  logic [1:0] step_q;
  logic [31:0] wdt_cnt_q;
  logic [15:0] wake_cnt_q;
  logic [3:0] div_q;
  logic half_q;
  logic [7:0] reg_rdata_q;
  isp_bus_t bus_q;
  logic [15:0] branch_addr_q;
  logic branch_go_q;
  logic cpu_clk_en_q;
  logic tmr_clk_en_q;
  logic special_reset_q;
  logic pop_busy_q;
  logic osc_run_q;
  logic ack_active_q;

  isp_sync #(.WIDTH(8)) u_sync (
    .sys_clk(sys_clk),
    .srst(srst),
    .async_in({spi_compare_match, port2_bit7_wake_pin, hw_req}),
    .sync_out({wake_sync, req_sync})
  ); // [RULE5]

  // decode
  wire at_bound = core_in.boundary && st_q == ISP_ST_RUN;
  wire is_ei = at_bound && core_in.opcode == 8'h9f;
  // one pop in flight at a time; the partner may stretch its answer
  wire pop_go = st_q == ISP_ST_RET && !bus_done && !pop_busy_q;
  wire req_we = reg_wr && reg_addr == A_REQ && armed_q; // [RULE9]
  wire [5:0] rise = req_sync & ~edge_q;
  wire [5:0] enabled = req_q & mask_q[5:0];
  wire [2:0] winner = pick(enabled, prio_q);
  wire take = at_bound && mask_q[ISP_MEN_BIT] && winner != 3'h7; // [RULE2] [RULE6]
  wire halt_op = at_bound && core_in.opcode == ISP_OP_HALT; // [RULE12]
  wire stop_op = at_bound && core_in.opcode == ISP_OP_STOP; // [RULE17]
  wire wake_lvl = src_q[ISP_SRC_POL_BIT] ? wake_sync[0] : ~wake_sync[0]; // [RULE25] [RULE20]
  wire wake_hit = (wake_cnt_q >= 16'(WAKE_MIN_CYC)) || wake_sync[1]; // [RULE22]
  wire wdt_hit = wdt_stop_enable && wdt_cnt_q >= 32'(WDT_STOP_CYC); // [RULE19]
  wire [5:0] clr_won = (st_q == ISP_ST_ACK && ack_cnt_q == 5'd0) ? 6'(1 << lvl_q) : 6'h00;
  wire tick = (src_q[ISP_SRC_FULL_BIT] || half_q) && (!src_q[ISP_SRC_DIV16_BIT] || div_q == 4'hf);
  wire [15:0] vec_addr = ISP_VEC_BASE + 16'({lvl_q, 1'b0});

  // request latch: set wins over software clear
  always_comb begin
    req_d = req_q;
    if (req_we) req_d = reg_wdata[5:0]; // [RULE1]
    req_d = (req_d & ~clr_won) | (armed_q ? rise : 6'h00); // [RULE8]
    if (!armed_q) req_d = 6'h00; // [RULE10]
  end

  always_comb begin
    st_d = st_q;
    case (st_q)
      ISP_ST_RUN: begin
        if (take) st_d = ISP_ST_ACK;
        else if (halt_op) st_d = ISP_ST_HALT; // [RULE11]
        else if (stop_op) st_d = ISP_ST_STOP; // [RULE16]
        else if (at_bound && core_in.opcode == 8'hbf) st_d = ISP_ST_RET;
      end
      ISP_ST_ACK: if (ack_cnt_q == 5'(ISP_ACK_CYCLES - 1)) st_d = ISP_ST_RUN; // [RULE4]
      ISP_ST_HALT: if (|req_q) st_d = ISP_ST_RUN; // [RULE13]
      ISP_ST_STOP: if (wake_hit || wdt_hit) st_d = ISP_ST_RUN; // [RULE18]
      ISP_ST_RET: if (bus_done && step_q == 2'd2) st_d = ISP_ST_RUN;
      default: st_d = ISP_ST_RUN;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      st_q <= ISP_ST_RUN;
      req_q <= 6'h00;
      edge_q <= 6'h00;
      mask_q <= ISP_MASK_RESET; // [RULE10]
      prio_q <= ISP_PRIO_RESET;
      src_q <= ISP_SRC_RESET; // [RULE26]
      armed_q <= 1'b0;
      ack_cnt_q <= 5'd0;
      lvl_q <= 3'd0;
      step_q <= 2'd0;
      pop_busy_q <= 1'b0;
      wdt_cnt_q <= 32'd0;
      wake_cnt_q <= 16'd0;
      div_q <= 4'h0;
      half_q <= 1'b0;
    end else begin
      st_q <= st_d;
      edge_q <= req_sync;
      req_q <= req_d;
      div_q <= (src_q[ISP_SRC_FULL_BIT] || half_q) ? div_q + 4'h1 : div_q; // [RULE23]
      half_q <= ~half_q; // [RULE24]
      if (reg_wr && reg_addr == A_MASK) mask_q <= reg_wdata;
      if (reg_wr && reg_addr == A_PRIO) prio_q <= reg_wdata[5:0];
      // clock scaling takes effect on the next tick, halted or not
      if (reg_wr && reg_addr == A_SRC) begin
        src_q[6:0] <= reg_wdata[6:0]; // [RULE15]
      end
      if (is_ei) begin
        mask_q[ISP_MEN_BIT] <= 1'b1; // [RULE7]
        armed_q <= 1'b1; // [RULE9]
      end
      if (at_bound && core_in.opcode == 8'h8f) mask_q[ISP_MEN_BIT] <= 1'b0;
      if (take) begin
        lvl_q <= winner;
        mask_q[ISP_MEN_BIT] <= 1'b0;
      end
      if (st_q == ISP_ST_ACK) ack_cnt_q <= ack_cnt_q + 5'd1;
      else ack_cnt_q <= 5'd0;
      if (st_q == ISP_ST_RET && bus_done) step_q <= step_q + 2'd1;
      else if (st_q != ISP_ST_RET) step_q <= 2'd0;
      if (st_q != ISP_ST_RET || bus_done) pop_busy_q <= 1'b0;
      else pop_busy_q <= 1'b1;
      if (st_q == ISP_ST_RET && st_d == ISP_ST_RUN) mask_q[ISP_MEN_BIT] <= 1'b1; // [RULE27]
      if (st_q == ISP_ST_STOP) begin
        wdt_cnt_q <= wdt_stop_enable ? wdt_cnt_q + 32'd1 : 32'd0;
        wake_cnt_q <= wake_lvl ? wake_cnt_q + 16'd1 : 16'd0;
        src_q[ISP_SRC_WARM_BIT] <= wake_hit; // [RULE26]
      end else begin
        wdt_cnt_q <= 32'd0;
        wake_cnt_q <= 16'd0;
      end
    end
  end

  // core-facing outputs, all registered
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      reg_rdata_q <= 8'h00;
      bus_q <= '0;
      branch_addr_q <= ISP_RESET_ADDR;
      branch_go_q <= 1'b0;
      cpu_clk_en_q <= 1'b1;
      tmr_clk_en_q <= 1'b0;
      special_reset_q <= 1'b0;
      osc_run_q <= 1'b1;
      ack_active_q <= 1'b0;
    end else begin
      reg_rdata_q <= 8'h00;
      if (reg_rd && reg_addr == A_REQ) reg_rdata_q <= {2'b00, req_q};
      else if (reg_rd && reg_addr == A_MASK) reg_rdata_q <= mask_q;
      else if (reg_rd && reg_addr == A_SRC) reg_rdata_q <= {src_q[ISP_SRC_WARM_BIT], 7'h00};
      bus_q <= '0;
      branch_go_q <= 1'b0;
      if (st_q == ISP_ST_ACK) begin
        case (ack_cnt_q)
          5'd1: bus_q <= '{op: ISP_BOP_PUSH, sel: 2'd0, addr: core_pc}; // [RULE3]
          5'd5: bus_q <= '{op: ISP_BOP_PUSH, sel: 2'd1, addr: core_pc};
          5'd9: bus_q <= '{op: ISP_BOP_PUSH, sel: 2'd2, addr: core_pc};
          5'd13: bus_q <= '{op: ISP_BOP_FETCH, sel: 2'd1, addr: vec_addr};
          5'd17: bus_q <= '{op: ISP_BOP_FETCH, sel: 2'd0, addr: vec_addr + 16'h1};
          5'd23: begin
            branch_addr_q <= vec_data;
            branch_go_q <= 1'b1;
          end
          default: bus_q <= '0;
        endcase
      end
      if (pop_go) begin
        bus_q <= '{op: ISP_BOP_POP, sel: 2'd2 - step_q, addr: core_pc}; // [RULE27]
      end
      if (st_q == ISP_ST_STOP && st_d == ISP_ST_RUN) begin
        branch_addr_q <= ISP_RESET_ADDR; // [RULE18] [RULE14]
        branch_go_q <= 1'b1;
        special_reset_q <= 1'b1; // [RULE21]
      end else begin
        special_reset_q <= 1'b0;
      end
      cpu_clk_en_q <= (st_d == ISP_ST_RUN || st_d == ISP_ST_ACK || st_d == ISP_ST_RET) && tick;
      tmr_clk_en_q <= st_d != ISP_ST_STOP && tick; // [RULE11] [RULE16]
      osc_run_q <= st_d != ISP_ST_STOP; // [RULE16]
      ack_active_q <= st_d == ISP_ST_ACK; // [RULE4]
    end
  end

  assign reg_rdata = reg_rdata_q;
  assign bus_out = bus_q;
  assign branch_addr = branch_addr_q;
  assign branch_go = branch_go_q;
  assign cpu_clk_en = cpu_clk_en_q;
  assign tmr_clk_en = tmr_clk_en_q;
  assign special_reset = special_reset_q;
  assign osc_run = osc_run_q;
  assign ack_active = ack_active_q;
endmodule : isp_top

// File: hdl/isp_pkg.sv
// Purpose: shared constants and types for the interrupt sequencer and power-down block
// Assumes: 250 MHz sys_clk, synchronous active-high reset
// Notes: core-side handshake is a plain level/pulse interface, no bus
//
// Functional notes
// RULE1 - writes to request register set bits handled like hardware requests
// RULE2 - vector only with master enable, level unmasked, no higher pending
// RULE3 - push pc low, pc high, flags; fetch vector high, low; branch
// RULE4 - acknowledge sequence lasts 24 internal clock cycles
// RULE5 - each request passes two synchronising flip-flops before arbitration
// RULE6 - requests recognised only at instruction boundaries
// RULE7 - enable-interrupts inside a routine re-arms master enable for nesting
// RULE8 - masked level still latches its request bit for polling
// RULE9 - request register operational only after first enable-interrupts
// RULE10 - reset clears master enable and holds request register cleared
// RULE11 - halt stops execution, gates cpu clock, timers and interrupts run
// RULE12 - opcode 7f decoded as halt; software precedes it with ff
// RULE13 - any interrupt ends halt; execution resumes after the halt
// RULE14 - halt ended by reset or watchdog restarts at 000c; here the watchdog counts only in stop and never ends halt
// RULE15 - rewriting clock bits 0/1 rescales clocks on the fly, even halted
// RULE16 - stop turns off oscillator and system clock, watchdog optional
// RULE17 - opcode 6f decoded as stop; software precedes it with ff
// RULE18 - stop ends only by reset, watchdog or recovery source, restart 000c
// RULE19 - watchdog running in stop resets a fixed period after entry
// RULE20 - low level on port2 bit7 triggers recovery, minimum pulse width
// RULE21 - recovery or stop watchdog reset initialises registers differently
// RULE22 - spi slave compare match also serves as recovery source
// RULE23 - control bit 0 enables divide-by-16 prescaler on system clocks
// RULE24 - control bit 1 bypasses divide-by-two of the oscillator
// RULE25 - control bit 6 selects wake polarity, 1 high, 0 low
// RULE26 - read-only bit 7 reads 0 on cold start, 1 on warm start
// RULE27 - return pops flags, pc high, pc low and re-enables master enable
package isp_pkg;
  localparam int ISP_LEVELS = 6;
  localparam logic [7:0] ISP_OP_HALT = 8'h7f;
  localparam logic [7:0] ISP_OP_STOP = 8'h6f;
  localparam logic [7:0] ISP_OP_NOP = 8'hff;
  localparam logic [15:0] ISP_RESET_ADDR = 16'h000c;
  localparam int ISP_ACK_CYCLES = 24;
  localparam int ISP_SYNC_STAGES = 2;
  localparam int ISP_WAKE_MIN_NS = 20;
  localparam int ISP_CLK_MHZ = 250;
  localparam int ISP_WAKE_MIN_CYC = (ISP_WAKE_MIN_NS * ISP_CLK_MHZ + 999) / 1000;
  localparam int ISP_WDT_STOP_CYC = 8192;
  localparam int ISP_MEN_BIT = 7;
  localparam int ISP_SRC_DIV16_BIT = 0;
  localparam int ISP_SRC_FULL_BIT = 1;
  localparam int ISP_SRC_POL_BIT = 6;
  localparam int ISP_SRC_WARM_BIT = 7;
  localparam logic [7:0] ISP_SRC_RESET = 8'h20;
  localparam logic [7:0] ISP_MASK_RESET = 8'h00;
  localparam logic [5:0] ISP_PRIO_RESET = 6'h00;
  // vector table base: level n vector at 2n
  localparam logic [15:0] ISP_VEC_BASE = 16'h0000;

  typedef enum logic [2:0] {
    ISP_ST_RUN = 3'b000,
    ISP_ST_ACK = 3'b001,
    ISP_ST_HALT = 3'b010,
    ISP_ST_STOP = 3'b011,
    ISP_ST_RET = 3'b100
  } isp_state_t;

  typedef enum logic [2:0] {
    ISP_BOP_NONE = 3'b000,
    ISP_BOP_PUSH = 3'b001,
    ISP_BOP_POP = 3'b010,
    ISP_BOP_FETCH = 3'b011
  } isp_bop_t;

  // one stack or program-memory access requested of the core
  typedef struct packed {
    isp_bop_t op;
    logic [1:0] sel; // 0 pc low, 1 pc high, 2 flags
    logic [15:0] addr;
  } isp_bus_t;

  // core instruction-boundary report
  typedef struct packed {
    logic boundary;
    logic [7:0] opcode;
  } isp_core_t;
endpackage : isp_pkg

// File: hdl/isp_sync.sv
// Purpose: two-stage synchroniser for request and wake inputs
// Assumes: asynchronous inputs, one clock
// Notes: first stage feeds only the second stage
`timescale 1ns/1ps
module isp_sync #(
  parameter int WIDTH = 6
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic srst,
  // data
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= async_in;
      sync_q <= meta_q;
    end
  end

  assign sync_out = sync_q;
endmodule : isp_sync

// File: verif/isp_props.sv
// Purpose: port assertions for isp_top
// Assumes: ticks at full rate while sequencing
// Notes: tag below packs op and sel of bus_out
`timescale 1ns/1ps
module isp_props
  import isp_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic srst,
  // watched ports
  input wire isp_pkg::isp_core_t core_in,
  input wire isp_pkg::isp_bus_t bus_out,
  input wire logic [15:0] branch_addr,
  input wire logic branch_go,
  input wire logic cpu_clk_en,
  input wire logic tmr_clk_en,
  input wire logic special_reset
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);
  // 04..06 push pc low, pc high, flags; 0a..08 pop flags, pc high, pc low
  wire logic [4:0] tag = {bus_out.op, bus_out.sel};
  wire logic fetch = bus_out.op == ISP_BOP_FETCH;
  wire logic halt_op = core_in.boundary && core_in.opcode == ISP_OP_HALT;
  wire logic stop_op = core_in.boundary && core_in.opcode == ISP_OP_STOP;
  wire logic ret_op = core_in.boundary && core_in.opcode == 8'hbf;
  chk_push_order: assert property (tag == 5'h04 |-> ##4 tag == 5'h05 ##4 tag == 5'h06)
    else $error("push order wrong");
  chk_vector_fetch: assert property (tag == 5'h06 |-> ##4 fetch ##4 fetch)
    else $error("vector fetch missing");
  chk_ack_length: assert property (tag == 5'h04 |-> ##22 branch_go)
    else $error("acknowledge length wrong");
  chk_branch_source: assert property (branch_go && !special_reset |-> $past(fetch, 6))
    else $error("branch without fetch");
  chk_halt_gate: assert property (halt_op |=> !cpu_clk_en [*2])
    else $error("cpu clock runs in halt");
  chk_stop_clocks: assert property (stop_op |=> !cpu_clk_en && !tmr_clk_en)
    else $error("clocks run in stop");
  chk_ret_pop: assert property (ret_op |-> ##[1:8] tag == 5'h0a)
    else $error("return pops no flags");
  chk_pop_order: assert property (tag == 5'h0a |-> ##[1:30] tag == 5'h09)
    else $error("pc high pop missing");
  chk_pop_pc: assert property (tag == 5'h09 |-> ##[1:30] tag == 5'h08)
    else $error("pc low pop missing");
  chk_wake_addr: assert property ($rose(special_reset) |-> ##[0:2] branch_addr == ISP_RESET_ADDR)
    else $error("wake address wrong");
  cover property (tag == 5'h04);
  cover property (tag == 5'h08);
  cover property (special_reset);
endmodule : isp_props

bind isp_top isp_props u_props (.sys_clk, .srst, .core_in, .bus_out, .branch_addr, .branch_go,
  .cpu_clk_en, .tmr_clk_en, .special_reset);

// File: verif/isp_core_model.sv
// Purpose: core-side partner answering pops and vector fetches
// Assumes: one sys_clk domain
// Notes: log_q keeps every request for the bench
`timescale 1ns/1ps
module isp_core_model
  import isp_pkg::*;
#(
  parameter logic [15:0] VEC_TAG = 16'h4000
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic srst,
  // sequencer side
  input wire isp_pkg::isp_bus_t bus_out,
  input wire logic [3:0] pop_wait,
  output logic bus_done,
  output logic [15:0] vec_data,
  output logic [15:0] core_pc
);
  isp_bus_t log_q[$];
  logic [15:0] vec_q;
  logic [4:0] wait_q;
  wire logic [15:0] vec_word = VEC_TAG | {bus_out.addr[15:1], 1'b0};
  // word shown in the fetch cycle and held, as a latched bus would
  assign vec_data = (bus_out.op == ISP_BOP_FETCH) ? vec_word : vec_q;
  assign core_pc = 16'h0345;
  assign bus_done = wait_q == 5'h01;
  always @(posedge sys_clk) begin
    if (srst) begin
      vec_q <= 16'hffff;
      wait_q <= 5'h00;
    end else begin
      if (bus_out.op != ISP_BOP_NONE) log_q.push_back(bus_out);
      if (bus_out.op == ISP_BOP_FETCH) vec_q <= vec_word;
      // slow answers stretch each pop by pop_wait cycles
      if (bus_out.op == ISP_BOP_POP) wait_q <= {1'b0, pop_wait} + 5'h01;
      else if (wait_q != 5'h00) wait_q <= wait_q - 5'h01;
    end
  end
endmodule : isp_core_model

// File: verif/tb.sv
// Purpose: self-checking bench for isp_top
// Assumes: ei 9f, di 8f, return bf; priority 01 orders levels 1,4,5,3,2,0
// Notes: control 02 keeps ticks at full rate
`timescale 1ns/1ps
module tb;
  import isp_pkg::*;
  localparam int WDT_CYC = 16;
  localparam logic [15:0] VEC_TAG = 16'h4000;
  localparam logic [7:0] SCL [4] = '{8'h00, 8'h03, 8'h01, 8'h02};
  localparam int HI [4] = '{16, 2, 1, 32};
  logic sys_clk = 1'b0;
  logic srst = 1'b1;
  logic [1:0] reg_addr = 2'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [ISP_LEVELS-1:0] hw_req = '0;
  logic wake_pin = 1'b1;
  logic wdt_en = 1'b0;
  logic spi_match = 1'b0;
  logic osc_run, ack_active;
  logic [3:0] pop_wait = 4'h0;
  isp_core_t core_in = '0;
  isp_bus_t bus_out;
  logic [7:0] reg_rdata;
  logic [15:0] core_pc, vec_data, branch_addr;
  logic bus_done, branch_go, cpu_clk_en, tmr_clk_en, special_reset;
  int fails = 0;
  int check_count = 0;
  int n;
  always #2 sys_clk = ~sys_clk;
  isp_top #(.WDT_STOP_CYC(WDT_CYC), .WAKE_MIN_CYC(ISP_WAKE_MIN_CYC)) DUT (
    .sys_clk, .srst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .hw_req,
    .port2_bit7_wake_pin(wake_pin), .spi_compare_match(spi_match), .wdt_stop_enable(wdt_en),
    .core_in, .core_pc, .vec_data, .bus_done, .bus_out, .branch_addr, .branch_go,
    .cpu_clk_en, .osc_run, .tmr_clk_en, .special_reset, .ack_active);
  isp_core_model #(.VEC_TAG(VEC_TAG)) core (.sys_clk, .srst, .bus_out, .pop_wait,
    .bus_done, .vec_data, .core_pc);
  task automatic close_out();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : close_out
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [1:0] a, input logic [7:0] e, input logic [7:0] m);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 check({8'h00, reg_rdata & m}, {8'h00, e & m});
  endtask : rd
  task automatic bnd(input logic [7:0] op);
    @(posedge sys_clk);
    core_in <= {1'b1, op};
    @(posedge sys_clk);
    core_in <= {1'b0, op};
  endtask : bnd
  // bounded wait, n returns the cycles taken
  task automatic wait_hi(ref logic s, input int lim);
    n = 0;
    while (s !== 1'b1) begin
      @(posedge sys_clk);
      #1 n++;
      if (n > lim) begin
        fails++;
        close_out();
      end
    end
  endtask : wait_hi
  task automatic ack_chk(input int lvl);
    #1 check({15'h0, ack_active}, 16'h0001);
    wait_hi(branch_go, 80);
    check(16'(core.log_q.size()), 16'd5);
    for (int i = 0; i < 3; i++)
      check({11'h0, core.log_q[i].op, core.log_q[i].sel}, {11'h0, ISP_BOP_PUSH, 2'(i)});
    check(core.log_q[3].addr, ISP_VEC_BASE + 16'(2 * lvl));
    check(branch_addr, VEC_TAG | 16'(2 * lvl));
    core.log_q.delete();
  endtask : ack_chk
  task automatic ret_done();
    bnd(8'hbf);
    for (n = 0; n < 80 && core.log_q.size() < 3; n++) begin
      @(posedge sys_clk);
      #1;
    end
    if (n >= 80) begin
      fails++;
      close_out();
    end
    // let the last pop answer land before the next boundary
    repeat (8) @(posedge sys_clk);
    for (int i = 0; i < 3; i++)
      check({11'h0, core.log_q[i].op, core.log_q[i].sel}, {11'h0, ISP_BOP_POP, 2'(2 - i)});
    core.log_q.delete();
  endtask : ret_done
  initial begin
    repeat (5) @(posedge sys_clk);
    srst <= 1'b0;
    rd(2'd1, 8'h00, 8'h80);
    rd(2'd3, 8'h00, 8'hff);
    wr(2'd0, 8'h04);
    rd(2'd0, 8'h00, 8'hff);
    for (int i = 0; i < 4; i++) begin
      wr(2'd3, SCL[i]);
      // let the old divider phase run out before counting
      repeat (40) @(posedge sys_clk);
      n = 0;
      repeat (32) begin
        @(posedge sys_clk);
        #1 n += int'(cpu_clk_en);
      end
      check(16'(n), 16'(HI[i]));
    end
    bnd(8'h9f);
    bnd(8'h8f);
    wr(2'd1, 8'h00);
    hw_req <= 6'h04;
    repeat (4) @(posedge sys_clk);
    bnd(ISP_OP_NOP);
    rd(2'd0, 8'h04, 8'h3f);
    check(16'(core.log_q.size()), 16'd0);
    @(posedge sys_clk);
    hw_req <= '0;
    wr(2'd0, 8'h00);
    rd(2'd0, 8'h00, 8'h3f);
    wr(2'd2, 8'h01);
    wr(2'd1, 8'h3f);
    bnd(8'h9f);
    wr(2'd0, 8'h03);
    repeat (8) @(posedge sys_clk);
    check(16'(core.log_q.size()), 16'd0);
    bnd(ISP_OP_NOP);
    ack_chk(1);
    wr(2'd0, 8'h21);
    bnd(8'h9f);
    bnd(ISP_OP_NOP);
    ack_chk(5);
    pop_wait <= 4'h3;
    ret_done();
    bnd(ISP_OP_NOP);
    ack_chk(0);
    ret_done();
    bnd(ISP_OP_NOP);
    bnd(ISP_OP_HALT);
    repeat (3) @(posedge sys_clk);
    #1 check({13'h0, osc_run, cpu_clk_en, tmr_clk_en}, 16'h0005);
    @(posedge sys_clk);
    hw_req <= 6'h10;
    wait_hi(cpu_clk_en, 40);
    check(16'(n >= ISP_SYNC_STAGES), 16'h0001);
    @(posedge sys_clk);
    hw_req <= '0;
    core.log_q.delete();
    bnd(ISP_OP_NOP);
    ack_chk(4);
    ret_done();
    bnd(ISP_OP_NOP);
    bnd(ISP_OP_STOP);
    repeat (3) @(posedge sys_clk);
    #1 check({13'h0, osc_run, cpu_clk_en, tmr_clk_en}, 16'h0000);
    @(posedge sys_clk);
    wake_pin <= 1'b0;
    repeat (2) @(posedge sys_clk);
    wake_pin <= 1'b1;
    repeat (10) @(posedge sys_clk);
    #1 check({15'h0, tmr_clk_en}, 16'h0000);
    @(posedge sys_clk);
    wake_pin <= 1'b0;
    wait_hi(special_reset, 30);
    check(16'(n >= ISP_WAKE_MIN_CYC), 16'h0001);
    @(posedge sys_clk);
    wake_pin <= 1'b1;
    @(posedge sys_clk);
    #1 check(branch_addr, ISP_RESET_ADDR);
    rd(2'd3, 8'h80, 8'h80);
    wr(2'd3, 8'h02);
    wdt_en <= 1'b1;
    bnd(ISP_OP_NOP);
    bnd(ISP_OP_STOP);
    wait_hi(special_reset, 3 * WDT_CYC);
    check(16'(n >= WDT_CYC - 2), 16'h0001);
    rd(2'd3, 8'h00, 8'h80);
    wdt_en <= 1'b0;
    // high wake polarity: the idle-high pin itself wakes
    wr(2'd3, 8'h42);
    bnd(ISP_OP_NOP);
    bnd(ISP_OP_STOP);
    wait_hi(special_reset, 20);
    check(16'(n >= ISP_WAKE_MIN_CYC), 16'h0001);
    rd(2'd3, 8'h80, 8'h80);
    wr(2'd3, 8'h02);
    bnd(ISP_OP_NOP);
    bnd(ISP_OP_STOP);
    @(posedge sys_clk);
    spi_match <= 1'b1;
    wait_hi(special_reset, 8);
    check(16'(n <= ISP_SYNC_STAGES + 1), 16'h0001);
    spi_match <= 1'b0;
    close_out();
  end
endmodule : tb
